// >>> dram_addr_split.sv
`default_nettype none
module dram_addr_split (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // access request
  input wire logic load,
  input wire logic [23:0] addr,
  input wire logic [1:0] mux_sel,
  input wire logic word_bus,
  // registered row and column halves
  output logic [11:0] row_addr,
  output logic [11:0] col_addr
);

  logic [23:0] unit_addr; // address in bus-width units
  logic [11:0] next_row;
  logic [11:0] next_col;

  // split by multiplex width; a word bus drops the byte select bit first
  always_comb begin
    unit_addr = word_bus ? {1'b0, addr[23:1]} : addr;
    next_row = 12'h000;
    next_col = 12'h000;
    unique case (mux_sel)
      2'h0: begin
        next_col = {3'h0, unit_addr[8:0]};
        next_row = unit_addr[20:9];
      end
      2'h1: begin
        next_col = {2'h0, unit_addr[9:0]};
        next_row = unit_addr[21:10];
      end
      2'h2: begin
        next_col = {1'h0, unit_addr[10:0]};
        next_row = unit_addr[22:11];
      end
      2'h3: begin
        next_col = unit_addr[11:0];
        next_row = unit_addr[23:12];
      end
    endcase
  end

  // held for the whole access so the memory side sees stable halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_addr <= 12'h000;
      col_addr <= 12'h000;
    end else if (load) begin
      row_addr <= next_row;
      col_addr <= next_col;
    end
  end

endmodule
`default_nettype wire

// >>> dram_and_dma_wait_config.sv
// Function
// RQ1: dma dram waits two to five cycles
// RQ2: dma dram field independent of normal waits
// RQ3: dma cs waits zero to fifteen
// RQ4: dma cs field independent of cs waits
// RQ5: dma register bits fifteen to six zero
// RQ6: software sets dma register before transfers
// RQ7: dma register resets to 000f
// RQ8: dram register resets to zero
// RQ9: software writes dram register once only
// RQ10: no dram access before dram setup
// RQ11: precharge 1.5 or 2.5 cycles
// RQ12: row address one or two cycles
// RQ13: refresh row strobe 2.5 to 5.5
// RQ14: write column cycles two to five
// RQ15: read column cycles two to five
// RQ16: idle cycle after dram read optionally
// RQ17: burst bit enables page mode
// RQ18: row strobe up or down mode
// RQ19: bit three written zero, reads zero
// RQ20: bus width eight or sixteen bits
// RQ21: multiplex width nine to twelve bits
// RQ22: dram register bit six reads zero
// RQ23: settings latched at access start
//
// The address map and the APB register port are this design's own decisions.
`default_nettype none
module dram_and_dma_wait_config (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // access request from the bus state machine
  input wire logic access_start,
  input wire logic access_dram,
  input wire logic access_write,
  input wire logic access_dma_single,
  input wire logic [23:0] access_addr,
  input wire logic [3:0] normal_cs_waits,
  // refresh request
  input wire logic refresh_start,
  // per-access timing selection
  output logic [2:0] column_cycles,
  output logic ext_wait_enable,
  output logic [3:0] cs_wait_count,
  output logic [2:0] precharge_half_cycles,
  output logic [1:0] row_address_cycles,
  output logic idle_cycle_insert,
  output logic page_mode,
  output logic row_strobe_hold,
  output logic word_bus,
  output logic [3:0] mux_width,
  output logic [11:0] row_addr,
  output logic [11:0] col_addr,
  // refresh timing selection
  output logic [3:0] refresh_assert_half_cycles
);

  // timing choice only; counting is done outside
  // every selection but the refresh length is a flop loaded on access_start,
  // so a register write in mid-access cannot tear it
  // half-cycle figures travel as counts of half cycles,
  // so 1.5 and 2.5 cycles fit in whole numbers
  // no interrupt, no buffering, one clock domain

  // software registers
  logic [15:0] dma_single_address_wait_control; // dma single address waits
  logic [15:0] dram_area_control; // dram timing and geometry

  // apb phase decode
  logic setup_phase; // first cycle of a transfer
  logic access_done; // completing edge of a transfer
  logic hit_dma; // address names the dma wait register
  logic hit_dram; // address names the dram control register

  // state kept between accesses
  logic last_was_dram_read; // previous external access was a dram read

  // decoded fields of the dma register
  logic [1:0] dma_dram_setting;
  logic [3:0] dma_cs_setting;

  // decoded fields of the dram register
  logic [1:0] write_setting;
  logic [1:0] read_setting;
  logic [1:0] refresh_setting;
  logic [1:0] mux_setting;

  // choice for the access being started
  logic [1:0] next_dram_setting;
  logic [3:0] next_cs_setting;

  // lanes two and three carry nothing here;
  // their strobes are ignored, not refused,
  // so a full-word store lands normally
  // mask applied after the merge, so reserved
  // bits can never be stored by any strobe mix
  // merges the enabled low byte lanes into a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wdata,
                                             input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] merged;
    merged = old;
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    lane_merge = merged & mask;
  endfunction

  // only the low address byte is decoded;
  // the fabric in front selects us through psel
  // a write lands only at the edge where psel,
  // penable and pready are all high
  // apb phases
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign hit_dma = (paddr == dram_cfg_pkg::dma_wait_offset);
  assign hit_dram = (paddr == dram_cfg_pkg::dram_ctrl_offset);

  // fields cut by package positions, so a
  // layout change is made in one place
  // field extraction
  assign dma_dram_setting = dma_single_address_wait_control[dram_cfg_pkg::dma_dram_wait_hi:
                                                            dram_cfg_pkg::dma_dram_wait_lo];
  assign dma_cs_setting = dma_single_address_wait_control[dram_cfg_pkg::dma_cs_wait_b3:
                                                          dram_cfg_pkg::dma_cs_wait_b0];
  assign write_setting = dram_area_control[dram_cfg_pkg::dram_write_wait_hi:
                                           dram_cfg_pkg::dram_write_wait_lo];
  assign read_setting = dram_area_control[dram_cfg_pkg::dram_read_wait_hi:
                                          dram_cfg_pkg::dram_read_wait_lo];
  assign refresh_setting = dram_area_control[dram_cfg_pkg::refresh_row_assert_hi:
                                             dram_cfg_pkg::refresh_row_assert_lo];
  assign mux_setting = dram_area_control[dram_cfg_pkg::addr_multiplex_hi:
                                         dram_cfg_pkg::addr_multiplex_lo];

  // dma and normal wait fields never mix:
  // this mux is the only place they meet and
  // it picks one side by the kind of access
  // normal cs waits come from the per-space
  // wait register outside this block
  // pick the wait setting of the access about to start
  always_comb begin
    // dma single address uses only its own fields
    if (access_dma_single) begin
      next_dram_setting = dma_dram_setting; // RQ1 RQ2
      next_cs_setting = dma_cs_setting; // RQ3 RQ4
    end else begin
      // normal accesses never look at the dma fields
      next_dram_setting = access_write ? write_setting : read_setting; // RQ14 RQ15 RQ2
      next_cs_setting = normal_cs_waits; // RQ4
    end
  end

  // zero-wait slave: pready rises in the first access cycle
  // driven by the setup cycle alone, so a setup
  // straight after a completed access gets its own
  // ready; holding ready low after a ready would stall it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // read data frozen at the setup edge; a write
  // lands at the end of the access cycle, so
  // it cannot reach the data of its own slot
  // writes answer zero so no stale word leaks out
  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      // unmapped addresses answer zero with an error
      pslverr <= !(hit_dma || hit_dram);
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else if (hit_dma) begin
        prdata <= {16'h0000, dma_single_address_wait_control}; // RQ5
      end else if (hit_dram) begin
        prdata <= {16'h0000, dram_area_control}; // RQ22 RQ19
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // only power-on reset reaches this register;
  // standby leaves presetn alone, so settings
  // survive it
  // until software programs it, the reset value
  // asks for 15 cs waits and the shortest dram phase
  // dma single address wait register; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_single_address_wait_control <= dram_cfg_pkg::dma_wait_reset; // RQ7
    end else if (access_done && pwrite && hit_dma) begin
      // software standby has no reset path here, so contents survive it
      dma_single_address_wait_control <= lane_merge(dma_single_address_wait_control, pwdata, pstrb,
                                                    dram_cfg_pkg::dma_wait_mask); // RQ5
    end
  end

  // reset value gives the shortest timings and
  // the byte bus, so no dram access may run
  // before software has written this register
  // bit three stays zero whatever is written
  // dram control register; bits six and three are held at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dram_area_control <= dram_cfg_pkg::dram_ctrl_reset; // RQ8
    end else if (access_done && pwrite && hit_dram) begin
      // a rewrite is accepted; keeping it one-time is up to software
      dram_area_control <= lane_merge(dram_area_control, pwdata, pstrb,
                                      dram_cfg_pkg::dram_ctrl_mask); // RQ22 RQ19
    end
  end

  // a cs access leaves column_cycles at zero and
  // a dram access leaves cs_wait_count at zero,
  // so the levels alone tell the access kind
  // wait pin gated here too, so the counter
  // outside never decodes the setting again
  // wait selection latched at access start so a late write cannot tear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column_cycles <= 3'h0;
      ext_wait_enable <= 1'b0;
      cs_wait_count <= 4'h0;
    end else if (access_start) begin
      if (access_dram) begin
        // dram: column phase length and wait pin gating
        column_cycles <= dram_cfg_pkg::column_cycles(next_dram_setting); // RQ1 RQ14 RQ15 RQ23
        ext_wait_enable <= dram_cfg_pkg::wait_ext_enabled(next_dram_setting); // RQ1 RQ14 RQ15
        cs_wait_count <= 4'h0;
      end else begin
        // chip select: zero waits also turns the wait pin off
        column_cycles <= 3'h0;
        cs_wait_count <= next_cs_setting; // RQ3 RQ23
        ext_wait_enable <= (next_cs_setting != 4'h0); // RQ3
      end
    end
  end

  // copies follow the register at access start
  // only; between accesses they keep the last
  // settings, which the row strobe hold mode needs
  // after reset: timings of an all-zero register
  // row timing and mode bits latched at access start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      precharge_half_cycles <= dram_cfg_pkg::precharge_half_short;
      row_address_cycles <= dram_cfg_pkg::row_cycles_short;
      page_mode <= 1'b0;
      row_strobe_hold <= 1'b0;
      word_bus <= 1'b0;
      mux_width <= dram_cfg_pkg::mux_bits_base;
    end else if (access_start) begin
      // precharge in half cycles: 3 means 1.5, 5 means 2.5
      precharge_half_cycles <= dram_area_control[dram_cfg_pkg::row_precharge_length] ?
                               dram_cfg_pkg::precharge_half_long :
                               dram_cfg_pkg::precharge_half_short; // RQ11 RQ23
      // row address stands one or two cycles before the column phase
      row_address_cycles <= dram_area_control[dram_cfg_pkg::row_to_column_delay] ?
                            dram_cfg_pkg::row_cycles_long :
                            dram_cfg_pkg::row_cycles_short; // RQ12
      // page mode bursts
      page_mode <= dram_area_control[dram_cfg_pkg::page_burst_enable]; // RQ17
      // row strobe kept low between accesses when set
      row_strobe_hold <= dram_area_control[dram_cfg_pkg::row_strobe_hold_mode]; // RQ18
      // sixteen-bit data bus when set
      word_bus <= dram_area_control[dram_cfg_pkg::dram_bus_width]; // RQ20
      // multiplex width nine plus the field
      mux_width <= dram_cfg_pkg::mux_bits_base + {2'h0, mux_setting}; // RQ21
    end
  end

  // idle choice needs the access before the one
  // now starting; dma single address dram reads
  // count as dram reads like any other
  // remember whether the last external access was a dram read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_was_dram_read <= 1'b0;
    end else if (access_start) begin
      last_was_dram_read <= access_dram && !access_write;
    end
  end

  // the idle cycle lets the memory release the
  // data bus after a read; it costs one cycle per
  // turn, which is why software chooses it
  // idle cycle only after a dram read followed by cs space or a dram write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cycle_insert <= 1'b0;
    end else if (access_start) begin
      // dram read after dram read needs no turnaround, so it gets none
      idle_cycle_insert <= dram_area_control[dram_cfg_pkg::post_read_idle_insert] &&
                           last_was_dram_read && (!access_dram || access_write); // RQ16
    end
  end

  // refresh has its own start pulse, so a refresh
  // between two accesses leaves their settings alone
  // 2.5 to 5.5 cycles, as 5 to 11 half cycles
  // refresh strobe length latched at refresh start, in half cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_assert_half_cycles <= dram_cfg_pkg::refresh_half_base;
    end else if (refresh_start) begin
      // 5, 7, 9 or 11 half cycles
      refresh_assert_half_cycles <= dram_cfg_pkg::refresh_half_base +
                                    {1'b0, refresh_setting, 1'b0}; // RQ13 RQ23
    end
  end

  // split uses width and multiplex bits as they
  // stand at access start, held until the next one
  // row and column split of the access address
  dram_addr_split dram_addr_split_i (
    .pclk(pclk),
    .presetn(presetn),
    .load(access_start),
    .addr(access_addr),
    .mux_sel(mux_setting),
    .word_bus(dram_area_control[dram_cfg_pkg::dram_bus_width]),
    .row_addr(row_addr),
    .col_addr(col_addr)
  ); // RQ21

endmodule
`default_nettype wire

// >>> dram_and_dma_wait_config_tb.sv
`default_nettype none
module dram_and_dma_wait_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, prev_rd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd, exp_s, exp_a;
  logic [31:0] seed = 32'h0000e84e; // fixed seed 59470
  logic [3:0] pstrb, cs_wait_count, mux_width, refresh_assert_half_cycles, normal_cs_waits;
  logic [2:0] column_cycles, precharge_half_cycles;
  logic [1:0] row_address_cycles;
  logic [11:0] row_addr, col_addr;
  logic [23:0] access_addr;
  logic [15:0] dma_v, dram_v;
  logic access_start, access_dram, access_write, access_dma_single, refresh_start;
  logic ext_wait_enable, idle_cycle_insert, page_mode, row_strobe_hold, word_bus;
  int errors, check_count, cyc;
  // free-running 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  dram_and_dma_wait_config dram_and_dma_wait_config_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .access_start, .access_dram, .access_write, .access_dma_single,
    .access_addr, .normal_cs_waits, .refresh_start, .column_cycles, .ext_wait_enable, .cs_wait_count,
    .precharge_half_cycles, .row_address_cycles, .idle_cycle_insert, .page_mode, .row_strobe_hold, .word_bus,
    .mux_width, .row_addr, .col_addr, .refresh_assert_half_cycles);
  ext_access_model ext_access_model_i (.pclk, .access_start, .access_dram, .access_write, .access_dma_single,
    .access_addr, .normal_cs_waits, .refresh_start);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected selection: r[0] dram, r[1] write, r[2] dma, r[6:3] normal cs waits
  function automatic logic [24:0] exp_sel(input logic [15:0] dw, dc, input logic [30:0] r, input logic pr);
    logic [1:0] s;
    logic [3:0] w;
    s = r[2] ? dw[5:4] : (r[1] ? dc[11:10] : dc[9:8]);
    w = r[2] ? dw[3:0] : r[6:3];
    if (r[0])
      w = 4'h0;
    else
      s = 2'h0;
    return {r[0] ? 3'h2 + {1'b0, s} : 3'h0, r[0] ? s[1] : (w != 4'h0), w, dc[15] ? 3'h5 : 3'h3,
      dc[14] ? 2'h2 : 2'h1, dc[7] & pr & (!r[0] | r[1]), dc[5], dc[4], dc[2], 4'h9 + {2'h0, dc[1:0]},
      4'h5 + {1'b0, dc[13:12], 1'b0}};
  endfunction
  // word bus drops the byte bit before the split
  function automatic logic [23:0] exp_addr(input logic [15:0] dc, input logic [23:0] a);
    logic [23:0] u;
    int m;
    u = a >> dc[2];
    m = 9 + dc[1:0];
    return {12'(u >> m), 12'(u & ((24'h1 << m) - 24'h1))};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {errors, check_count, cyc} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0000000f);
    apb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, 32'h00000000);
    // low lane only; reserved bits must drop
    apb(1'b1, 8'h04, 32'hffffffff, 4'h1);
    apb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, 32'h000000b7);
    apb(1'b1, 8'h00, 32'hffffffff, 4'hf);
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0000003f);
    apb(1'b0, 8'h08, 32'h0, 4'hf);
    chk({31'h0, err}, 32'h1);
    dma_v = 16'h003f;
    dram_v = 16'h00b7;
    prev_rd = 1'b0;
    // each access is followed by reprogramming before its selection is checked
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      ext_access_model_i.issue(seed[30:0], seed[31] ? 3 : 0);
      exp_s = {7'h0, exp_sel(dma_v, dram_v, seed[30:0], prev_rd)};
      exp_a = {8'h0, exp_addr(dram_v, seed[30:7])};
      prev_rd = seed[0] & !seed[1];
      rnd = xs(seed);
      seed = rnd;
      dma_v = {10'h0, rnd[5:0]};
      dram_v = rnd[31:16] & 16'hffb7;
      apb(1'b1, 8'h00, {16'h0, dma_v}, 4'hf);
      apb(1'b1, 8'h04, {16'h0, dram_v}, 4'hf);
      chk({7'h0, column_cycles, ext_wait_enable, cs_wait_count, precharge_half_cycles, row_address_cycles,
        idle_cycle_insert, page_mode, row_strobe_hold, word_bus, mux_width, refresh_assert_half_cycles},
        exp_s);
      chk({8'h0, row_addr, col_addr}, exp_a);
    end
    // mid-run power-on reset must bring back both reset values
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, 4'hf);
    chk(rd, 32'h0000000f);
    apb(1'b0, 8'h04, 32'h0, 4'hf);
    chk(rd, 32'h00000000);
    close_out();
  end
endmodule
bind dram_and_dma_wait_config dram_cfg_chk dram_cfg_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
  .paddr, .prdata, .access_start, .access_dram, .refresh_start, .column_cycles, .ext_wait_enable, .cs_wait_count,
  .precharge_half_cycles, .row_address_cycles, .mux_width, .refresh_assert_half_cycles);
`default_nettype wire

// >>> dram_cfg_chk.sv
`default_nettype none
module dram_cfg_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  // access side
  input wire logic access_start,
  input wire logic access_dram,
  input wire logic refresh_start,
  input wire logic [2:0] column_cycles,
  input wire logic ext_wait_enable,
  input wire logic [3:0] cs_wait_count,
  input wire logic [2:0] precharge_half_cycles,
  input wire logic [1:0] row_address_cycles,
  input wire logic [3:0] mux_width,
  input wire logic [3:0] refresh_assert_half_cycles
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, so one default for all
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read data is captured at the setup edge
  dma_rsv_a: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=> prdata[31:6] == 26'h0)
    else $error("dma register reserved bits not zero");
  dram_rsv_a: assert property (psel && !penable && !pwrite && paddr == 8'h04 |=> !prdata[6] && !prdata[3])
    else $error("dram register reserved bits not zero");
  // 4 and 5 cycle settings are exactly those with bit two set
  dram_wait_a: assert property (access_start && access_dram |=> column_cycles inside {[3'h2:3'h5]}
    && ext_wait_enable == column_cycles[2] && cs_wait_count == 4'h0) else $error("dram wait selection wrong");
  cs_wait_a: assert property (access_start && !access_dram |=> column_cycles == 3'h0
    && ext_wait_enable == (cs_wait_count != 4'h0)) else $error("cs wait selection wrong");
  precharge_a: assert property (precharge_half_cycles == 3'h3 || precharge_half_cycles == 3'h5)
    else $error("precharge length out of set");
  row_cyc_a: assert property (row_address_cycles inside {2'h1, 2'h2})
    else $error("row address cycles out of set");
  mux_width_a: assert property (mux_width inside {[4'h9:4'hc]})
    else $error("multiplex width out of range");
  refresh_len_a: assert property (refresh_start |=> refresh_assert_half_cycles[0]
    && refresh_assert_half_cycles inside {[4'h5:4'hb]}) else $error("refresh assert length wrong");
  // a register write in mid-access must not disturb the running selection
  hold_sel_a: assert property (!access_start |=> $stable(column_cycles) && $stable(cs_wait_count))
    else $error("selection changed without a new access");
  cover property (access_start && access_dram ##1 ext_wait_enable);
  cover property (access_start && !access_dram ##1 ext_wait_enable);
  cover property (psel && penable && pready && pwrite);
endmodule
`default_nettype wire

// >>> dram_cfg_pkg.sv
`default_nettype none
package dram_cfg_pkg;

  // byte addresses of the two registers on the apb slave
  localparam logic [7:0] dma_wait_offset = 8'h00;
  localparam logic [7:0] dram_ctrl_offset = 8'h04;

  // reset values after power-on
  localparam logic [15:0] dma_wait_reset = 16'h000f;
  localparam logic [15:0] dram_ctrl_reset = 16'h0000;

  // writable bits; everything else is held at zero
  localparam logic [15:0] dma_wait_mask = 16'h003f;
  localparam logic [15:0] dram_ctrl_mask = 16'hffb7;

  // field positions in dma_single_address_wait_control
  localparam int dma_dram_wait_hi = 5;
  localparam int dma_dram_wait_lo = 4;
  localparam int dma_cs_wait_b3 = 3;
  localparam int dma_cs_wait_b0 = 0;

  // field positions in dram_area_control
  localparam int row_precharge_length = 15;
  localparam int row_to_column_delay = 14;
  localparam int refresh_row_assert_hi = 13;
  localparam int refresh_row_assert_lo = 12;
  localparam int dram_write_wait_hi = 11;
  localparam int dram_write_wait_lo = 10;
  localparam int dram_read_wait_hi = 9;
  localparam int dram_read_wait_lo = 8;
  localparam int post_read_idle_insert = 7;
  localparam int page_burst_enable = 5;
  localparam int row_strobe_hold_mode = 4;
  localparam int dram_bus_width = 2;
  localparam int addr_multiplex_hi = 1;
  localparam int addr_multiplex_lo = 0;

  // timing counts; half-cycle figures are kept in half cycles
  localparam logic [2:0] base_column_cycles = 3'h2;
  localparam logic [1:0] ext_wait_min_setting = 2'h2;
  localparam logic [2:0] precharge_half_short = 3'h3;
  localparam logic [2:0] precharge_half_long = 3'h5;
  localparam logic [1:0] row_cycles_short = 2'h1;
  localparam logic [1:0] row_cycles_long = 2'h2;
  localparam logic [3:0] refresh_half_base = 4'h5;
  localparam logic [3:0] mux_bits_base = 4'h9;

  // column cycles for a two-bit wait setting: 2, 3, 4 or 5
  function automatic logic [2:0] column_cycles(input logic [1:0] setting);
    column_cycles = base_column_cycles + {1'b0, setting};
  endfunction

  // external wait is honoured only at the two longest settings
  function automatic logic wait_ext_enabled(input logic [1:0] setting);
    wait_ext_enabled = (setting >= ext_wait_min_setting);
  endfunction

endpackage
`default_nettype wire

// >>> ext_access_model.sv
`default_nettype none
module ext_access_model (
  // clock
  input wire logic pclk,
  // request toward the selector
  output logic access_start,
  output logic access_dram,
  output logic access_write,
  output logic access_dma_single,
  output logic [23:0] access_addr,
  output logic [3:0] normal_cs_waits,
  output logic refresh_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet until the first request
  initial begin
    {access_start, refresh_start, access_dram, access_write, access_dma_single} = 5'h0;
    access_addr = 24'h0;
    normal_cs_waits = 4'h0;
  end
  // one-cycle request; gap makes the state machine prompt or slow
  task automatic issue(input logic [30:0] r, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    access_start <= 1'b1;
    refresh_start <= 1'b1;
    access_dram <= r[0];
    access_write <= r[1];
    access_dma_single <= r[2];
    normal_cs_waits <= r[6:3];
    access_addr <= r[30:7];
    @(posedge pclk);
    access_start <= 1'b0;
    refresh_start <= 1'b0;
    // lines move once taken, so a late sample shows up
    access_dram <= ~r[0];
    access_addr <= ~r[30:7];
    normal_cs_waits <= ~r[6:3];
  endtask
endmodule
`default_nettype wire
